// file: design/stc_pkg.sv
// constants, types and register map of the timestamp clock synchroniser
// assumes a single 125 MHz clock and an AXI4-Lite register port
package stc_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_SEC = 1000000000;
  localparam int CLK_HZ = NS_PER_SEC / CLK_PERIOD_NS;
  localparam int MISS_WINDOW_MS = 1500;
  localparam int TOL_US = 1000;
  localparam int PULSE_WIDTH_NS = 100000000;
  localparam int CYC_PER_SEC = CLK_HZ;
  localparam int MISS_CYC = MISS_WINDOW_MS * (CLK_HZ / 1000);
  localparam int TOL_CYC = TOL_US * (CLK_HZ / 1000000);
  localparam logic [29:0] STEP_NS = 30'(CLK_PERIOD_NS);
  localparam logic [29:0] NS_WRAP = 30'(NS_PER_SEC);
  localparam logic [29:0] NS_HALF = 30'(NS_PER_SEC / 2);
  localparam logic [31:0] THRESH_RST = 32'h0000_0254;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_HOST_SEC = 8'h04;
  localparam logic [7:0] A_HOST_NS = 8'h08;
  localparam logic [7:0] A_THRESH = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_TIME_SEC = 8'h14;
  localparam logic [7:0] A_TIME_NS = 8'h18;
  localparam logic [7:0] A_FAIL = 8'h1C;
  localparam logic [7:0] A_RESYNC = 8'h20;
  localparam logic [7:0] A_FREQ = 8'h24;
  localparam logic [7:0] A_PHASE = 8'h28;
  localparam logic [7:0] A_WFREQ = 8'h2C;
  localparam logic [7:0] A_WPHASE = 8'h30;
  localparam logic [7:0] A_TOTAL = 8'h34;
  localparam logic [7:0] A_BAD = 8'h38;
  localparam logic [7:0] A_MISS = 8'h3C;
  localparam logic [7:0] A_IRQ_ST = 8'h40;
  localparam logic [7:0] A_IRQ_MASK = 8'h44;
  // control register fields
  localparam int CTRL_MUXIN_LSB = 0;
  localparam int CTRL_MUXOUT_LSB = 4;
  localparam int CMD_SET = 8;
  localparam int CMD_RESET = 9;
  localparam int CMD_CLR = 10;
  localparam int CMD_TICK = 11;
  localparam logic [2:0] MUXIN_NONE = 3'h0;
  localparam logic [2:0] MUXIN_DIFF = 3'h1;
  localparam logic [2:0] MUXIN_HOST = 3'h2;
  localparam logic [2:0] MUXIN_INTERNAL = 3'h3;
  localparam logic [2:0] MUXIN_AUXILIARY_INPUT = 3'h4;
  localparam logic [1:0] MUXOUT_NONE = 2'h0;
  localparam logic [1:0] MUXOUT_LOOP = 2'h1;
  localparam logic [1:0] MUXOUT_HOST = 2'h2;
  localparam logic [1:0] MUXOUT_MASTER = 2'h3;
  // interrupt bits
  localparam int IRQ_GAIN = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_BAD = 2;
  localparam int IRQ_MISS = 3;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_FREE = 2'b00,
    ST_ACQ = 2'b01,
    ST_LOCK = 2'b10
  } stc_lock_e;
  typedef struct packed {
    logic valid;
    logic bad;
    logic missed;
    logic [31:0] interval;
  } stc_pin_s;
endpackage

// file: design/stc_pulse_meas.sv
// pulse edge detector and interval classifier
// assumes the selected reference level is synchronous to aclk
`timescale 1ns/10ps
`default_nettype none
module stc_pulse_meas #(
  parameter int CYC_PER_SEC = stc_pkg::CYC_PER_SEC,
  parameter int MISS_CYC = stc_pkg::MISS_CYC,
  parameter int TOL_CYC = stc_pkg::TOL_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic pulse_lvl,
  output stc_pkg::stc_pin_s ev
);
  logic prev_r;
  logic first_r;
  logic [31:0] cnt_r;
  wire rise_w = enable & pulse_lvl & ~prev_r;
  wire [31:0] intv_w = cnt_r + 32'h0000_0001;
  wire early_w = intv_w < 32'(CYC_PER_SEC - TOL_CYC);
  wire late_w = intv_w > 32'(CYC_PER_SEC + TOL_CYC);
  wire miss_w = enable & ~rise_w & (cnt_r == 32'(MISS_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
      first_r <= 1'b1;
      cnt_r <= 32'h0000_0000;
      ev <= '0;
    end else begin
      prev_r <= pulse_lvl;
      ev.interval <= intv_w;
      // first pulse after a gap has no interval to judge
      ev.bad <= rise_w & ~first_r & (early_w | late_w);
      ev.valid <= rise_w & (first_r | ~(early_w | late_w));
      ev.missed <= miss_w;
      if (!enable) begin
        cnt_r <= 32'h0000_0000;
        first_r <= 1'b1;
      end else if (rise_w) begin
        cnt_r <= 32'h0000_0000;
        first_r <= 1'b0;
      end else if (miss_w) begin
        cnt_r <= 32'h0000_0000;
        first_r <= 1'b1;
      end else begin
        cnt_r <= intv_w;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/stc_sync_core.sv
// timestamp clock synchroniser: time counter, reference discipline,
// sync pulse output, statistics and AXI4-Lite register port
// assumes one 125 MHz clock and synchronous pulse inputs
`timescale 1ns/10ps
`default_nettype none
module stc_sync_core #(
  parameter int CYC_PER_SEC = stc_pkg::CYC_PER_SEC,
  parameter int MISS_CYC = stc_pkg::MISS_CYC,
  parameter int TOL_CYC = stc_pkg::TOL_CYC,
  parameter int PULSE_NS = stc_pkg::PULSE_WIDTH_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic differential_pulse_input_p,
  input wire logic differential_pulse_input_n,
  output logic differential_pulse_output_p,
  output logic differential_pulse_output_n,
  output logic differential_pulse_output_oe,
  output logic synchronized,
  output logic [31:0] timestamp_sec,
  output logic [29:0] timestamp_ns,
  output logic irq
);
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  // bus state
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  // configuration and time
  logic [2:0] mux_in_r;
  logic [1:0] mux_out_r;
  logic [31:0] host_sec_r;
  logic [29:0] host_ns_r;
  logic [31:0] thresh_r;
  logic [31:0] sec_r;
  logic [29:0] ns_r;
  logic signed [31:0] slew_r;
  logic tick_r;
  stc_pkg::stc_lock_e st_r;
  stc_pkg::stc_lock_e st_nxt;
  // statistics
  logic [31:0] fail_r;
  logic [31:0] resync_r;
  logic signed [31:0] freq_r;
  logic signed [31:0] phase_r;
  logic [31:0] wfreq_r;
  logic [31:0] wphase_r;
  logic [31:0] total_r;
  logic [31:0] bad_r;
  logic [31:0] miss_r;
  logic [3:0] irq_st_r;
  logic [3:0] irq_mask_r;
  stc_pkg::stc_pin_s ev;
  logic [31:0] rd_w;

  // write and read channel handshakes
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire b_done = s_axi_bvalid & s_axi_bready;
  wire aw_have_nxt = aw_take | (aw_have_r & ~wr_go);
  wire w_have_nxt = w_take | (w_have_r & ~wr_go);
  wire bvalid_nxt = wr_go | (s_axi_bvalid & ~b_done);
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // write decode
  wire [7:0] wa_w = {awaddr_r[7:2], 2'b00};
  wire ws_ctrl = wr_go & (wa_w == stc_pkg::A_CTRL);
  wire ws_hsec = wr_go & (wa_w == stc_pkg::A_HOST_SEC);
  wire ws_hns = wr_go & (wa_w == stc_pkg::A_HOST_NS);
  wire ws_thr = wr_go & (wa_w == stc_pkg::A_THRESH);
  wire ws_ist = wr_go & (wa_w == stc_pkg::A_IRQ_ST);
  wire ws_imask = wr_go & (wa_w == stc_pkg::A_IRQ_MASK);
  wire wr_ok = (wa_w <= stc_pkg::A_IRQ_MASK);
  wire cmd_byte = ws_ctrl & wstrb_r[1];
  wire cmd_set = cmd_byte & wdata_r[stc_pkg::CMD_SET];
  wire cmd_rst = cmd_byte & wdata_r[stc_pkg::CMD_RESET];
  wire cmd_clr = cmd_byte & wdata_r[stc_pkg::CMD_CLR];
  wire cmd_tick = cmd_byte & wdata_r[stc_pkg::CMD_TICK];
  wire [31:0] ctrl_new = merge({24'h00_0000, 2'b00, mux_out_r, 1'b0, mux_in_r}, wdata_r, wstrb_r);

  // reference selection
  wire diff_lvl = differential_pulse_input_p & ~differential_pulse_input_n;
  wire in_diff = (mux_in_r == stc_pkg::MUXIN_DIFF);
  wire in_int = (mux_in_r == stc_pkg::MUXIN_INTERNAL);
  wire src_active = in_diff | in_int;
  wire src_lvl = (in_diff & diff_lvl) | (in_int & tick_r);

  stc_pulse_meas #(
    .CYC_PER_SEC(CYC_PER_SEC),
    .MISS_CYC(MISS_CYC),
    .TOL_CYC(TOL_CYC)
  ) u_meas (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(src_active),
    .pulse_lvl(src_lvl),
    .ev(ev)
  );

  // phase error at the reference edge
  wire [31:0] ns_ext = {2'b00, ns_r};
  wire late_half = (ns_r >= stc_pkg::NS_HALF);
  wire signed [31:0] err_w = late_half ? $signed(ns_ext - 32'(stc_pkg::NS_PER_SEC))
                                       : $signed(ns_ext);
  wire [31:0] aerr_w = mag(err_w);
  wire pulse_ok = ev.valid & src_active;
  wire big_err = aerr_w > thresh_r;
  wire step_now = pulse_ok & big_err;
  wire trim_now = pulse_ok & ~big_err;
  wire signed [31:0] freq_w = $signed(ev.interval - 32'(CYC_PER_SEC));
  wire [31:0] afreq_w = mag(freq_w);
  wire missed_ev = ev.missed & src_active;

  // slewed advance of the counter
  wire [29:0] step_w = slew_r > 0 ? stc_pkg::STEP_NS + 30'h0000_0001 :
                       slew_r < 0 ? stc_pkg::STEP_NS - 30'h0000_0001 : stc_pkg::STEP_NS;
  wire signed [31:0] slew_dec = slew_r > 0 ? slew_r - 32'sh0000_0001 :
                                slew_r < 0 ? slew_r + 32'sh0000_0001 : slew_r;
  wire [29:0] ns_inc = ns_r + step_w;
  wire wrap_w = (ns_inc >= stc_pkg::NS_WRAP);

  // lock state
  always_comb begin
    st_nxt = st_r;
    if (cmd_rst || !src_active) begin
      st_nxt = stc_pkg::ST_FREE;
    end else begin
      case (st_r)
        stc_pkg::ST_FREE: st_nxt = stc_pkg::ST_ACQ;
        stc_pkg::ST_ACQ: begin
          if (trim_now) begin
            st_nxt = stc_pkg::ST_LOCK;
          end
        end
        stc_pkg::ST_LOCK: begin
          if (step_now || missed_ev) begin
            st_nxt = stc_pkg::ST_ACQ;
          end
        end
        default: st_nxt = stc_pkg::ST_FREE;
      endcase
    end
  end

  wire lost_ev = (st_r == stc_pkg::ST_LOCK) & (st_nxt != stc_pkg::ST_LOCK);
  wire gain_ev = (st_r != stc_pkg::ST_LOCK) & (st_nxt == stc_pkg::ST_LOCK);
  wire [3:0] irq_set = {missed_ev, ev.bad & src_active, lost_ev, gain_ev};
  wire [3:0] irq_clr = (ws_ist & wstrb_r[0]) ? wdata_r[3:0] : 4'h0;
  wire [3:0] irq_st_nxt = irq_set | (irq_st_r & ~irq_clr);

  // sync pulse output selection
  wire master_lvl = (ns_r < 30'(PULSE_NS));
  wire out_loop = (mux_out_r == stc_pkg::MUXOUT_LOOP);
  wire out_master = (mux_out_r == stc_pkg::MUXOUT_MASTER);
  wire out_en = out_loop | out_master;
  wire out_lvl = out_loop ? diff_lvl : master_lvl;

  // read decode
  wire [7:0] ra_w = {s_axi_araddr[7:2], 2'b00};
  always_comb begin
    rd_w = 32'h0000_0000;
    case (ra_w)
      stc_pkg::A_CTRL: rd_w = {24'h00_0000, 2'b00, mux_out_r, 1'b0, mux_in_r};
      stc_pkg::A_HOST_SEC: rd_w = host_sec_r;
      stc_pkg::A_HOST_NS: rd_w = {2'b00, host_ns_r};
      stc_pkg::A_THRESH: rd_w = thresh_r;
      stc_pkg::A_STATUS: rd_w = {28'h000_0000, st_r, ~src_active, synchronized};
      stc_pkg::A_TIME_SEC: rd_w = sec_r;
      stc_pkg::A_TIME_NS: rd_w = {2'b00, ns_r};
      stc_pkg::A_FAIL: rd_w = fail_r;
      stc_pkg::A_RESYNC: rd_w = resync_r;
      stc_pkg::A_FREQ: rd_w = freq_r;
      stc_pkg::A_PHASE: rd_w = phase_r;
      stc_pkg::A_WFREQ: rd_w = wfreq_r;
      stc_pkg::A_WPHASE: rd_w = wphase_r;
      stc_pkg::A_TOTAL: rd_w = total_r;
      stc_pkg::A_BAD: rd_w = bad_r;
      stc_pkg::A_MISS: rd_w = miss_r;
      stc_pkg::A_IRQ_ST: rd_w = {28'h000_0000, irq_st_r};
      stc_pkg::A_IRQ_MASK: rd_w = {28'h000_0000, irq_mask_r};
      default: rd_w = 32'h0000_0000;
    endcase
  end
  wire rd_ok = (ra_w <= stc_pkg::A_IRQ_MASK);

  // bus slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= stc_pkg::RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= stc_pkg::RESP_OK;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      s_axi_awready <= ~aw_have_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_have_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bresp <= wr_ok ? stc_pkg::RESP_OK : stc_pkg::RESP_SLVERR;
      end
      if (ar_take) begin
        s_axi_rdata <= rd_w;
        s_axi_rresp <= rd_ok ? stc_pkg::RESP_OK : stc_pkg::RESP_SLVERR;
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_in_r <= stc_pkg::MUXIN_DIFF;
      mux_out_r <= stc_pkg::MUXOUT_NONE;
      host_sec_r <= 32'h0000_0000;
      host_ns_r <= 30'h0000_0000;
      thresh_r <= stc_pkg::THRESH_RST;
      irq_mask_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= cmd_tick & in_int;
      if (cmd_rst) begin
        mux_in_r <= stc_pkg::MUXIN_DIFF;
        mux_out_r <= stc_pkg::MUXOUT_NONE;
      end else if (ws_ctrl) begin
        mux_in_r <= ctrl_new[stc_pkg::CTRL_MUXIN_LSB +: 3];
        mux_out_r <= ctrl_new[stc_pkg::CTRL_MUXOUT_LSB +: 2];
      end
      if (ws_hsec) begin
        host_sec_r <= merge(host_sec_r, wdata_r, wstrb_r);
      end
      if (ws_hns) begin
        host_ns_r <= 30'(merge({2'b00, host_ns_r}, wdata_r, wstrb_r));
      end
      if (ws_thr) begin
        thresh_r <= merge(thresh_r, wdata_r, wstrb_r);
      end
      if (ws_imask) begin
        irq_mask_r <= 4'(merge({28'h000_0000, irq_mask_r}, wdata_r, wstrb_r));
      end
    end
  end

  // time counter and discipline
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_r <= 32'h0000_0000;
      ns_r <= 30'h0000_0000;
      slew_r <= 32'sh0000_0000;
      st_r <= stc_pkg::ST_FREE;
    end else begin
      st_r <= st_nxt;
      if (cmd_set || cmd_rst) begin
        sec_r <= host_sec_r;
        ns_r <= host_ns_r;
        slew_r <= 32'sh0000_0000;
      end else if (step_now) begin
        sec_r <= sec_r + {31'h0000_0000, late_half};
        ns_r <= 30'h0000_0000;
        slew_r <= 32'sh0000_0000;
      end else begin
        ns_r <= wrap_w ? ns_inc - stc_pkg::NS_WRAP : ns_inc;
        sec_r <= sec_r + {31'h0000_0000, wrap_w};
        slew_r <= trim_now ? -err_w : slew_dec;
      end
    end
  end

  // statistics and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_clr || cmd_rst) begin
      fail_r <= 32'h0000_0000;
      resync_r <= 32'h0000_0000;
      freq_r <= 32'sh0000_0000;
      phase_r <= 32'sh0000_0000;
      wfreq_r <= 32'h0000_0000;
      wphase_r <= 32'h0000_0000;
      total_r <= 32'h0000_0000;
      bad_r <= 32'h0000_0000;
      miss_r <= 32'h0000_0000;
    end else begin
      if (step_now) begin
        resync_r <= resync_r + 32'h0000_0001;
      end
      if (lost_ev) begin
        fail_r <= fail_r + 32'h0000_0001;
      end
      if (pulse_ok) begin
        phase_r <= err_w;
        if (aerr_w > wphase_r) begin
          wphase_r <= aerr_w;
        end
      end
      if (pulse_ok && ev.bad == 1'b0 && total_r != 32'h0000_0000) begin
        freq_r <= freq_w;
        if (afreq_w > wfreq_r) begin
          wfreq_r <= afreq_w;
        end
      end
      if (src_active && (ev.valid || ev.bad)) begin
        total_r <= total_r + 32'h0000_0001;
      end
      if (src_active && ev.bad) begin
        bad_r <= bad_r + 32'h0000_0001;
      end
      if (missed_ev) begin
        miss_r <= miss_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_r <= 4'h0;
      irq <= 1'b0;
      synchronized <= 1'b0;
      timestamp_sec <= 32'h0000_0000;
      timestamp_ns <= 30'h0000_0000;
      differential_pulse_output_p <= 1'b0;
      differential_pulse_output_n <= 1'b0;
      differential_pulse_output_oe <= 1'b0;
    end else begin
      irq_st_r <= irq_st_nxt;
      irq <= |(irq_st_nxt & irq_mask_r);
      synchronized <= (st_nxt == stc_pkg::ST_LOCK);
      timestamp_sec <= sec_r;
      timestamp_ns <= ns_r;
      differential_pulse_output_p <= out_en & out_lvl;
      differential_pulse_output_n <= out_en & ~out_lvl;
      differential_pulse_output_oe <= out_en;
    end
  end
endmodule
`default_nettype wire

// file: test/stc_pps_src.sv
// pulse-per-second reference model driving the differential input
// assumes the bench enables it on a rising edge of aclk
`timescale 1ns/10ps
`default_nettype none
module stc_pps_src #(
  parameter int PERIOD = 1000,
  parameter int WIDTH = 50
) (
  input wire logic aclk,
  input wire logic en,
  output logic p,
  output logic n
);
  int cnt = 0;
  logic lvl = 1'b0;
  // one pulse per period from the enabling edge, idle low otherwise
  always @(posedge aclk) begin
    if (!en) begin
      cnt <= 0;
      lvl <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      lvl <= (cnt < WIDTH);
    end
  end
  assign p = lvl;
  assign n = ~lvl;
endmodule
`default_nettype wire

// file: test/stc_sync_asserts.sv
// port checker for the sync core: bus timing, output pins, reset state
// bound to stc_sync_core from the bench top, one aclk domain
`timescale 1ns/10ps
`default_nettype none
module stc_sync_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic differential_pulse_output_p,
  input wire logic differential_pulse_output_n,
  input wire logic differential_pulse_output_oe,
  input wire logic synchronized,
  input wire logic [29:0] timestamp_ns,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence w_busy;
    !s_axi_awready && !s_axi_wready;
  endsequence
  write_answer_a: assert property (aw_w_taken |=> w_busy ##1 (w_busy and s_axi_bvalid))
    else $error("write response not two cycles after take");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after take");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  busy_refuse_a: assert property (s_axi_bvalid |-> w_busy)
    else $error("write accepted while response pending");
  drive_pair_a: assert property (differential_pulse_output_oe |-> differential_pulse_output_p != differential_pulse_output_n)
    else $error("driven output pair not complementary");
  idle_pins_a: assert property (!differential_pulse_output_oe |-> !differential_pulse_output_p && !differential_pulse_output_n)
    else $error("undriven output pair not low");
  ns_range_a: assert property (timestamp_ns < 30'h3B9A_CA00)
    else $error("nanoseconds beyond one second");
  reset_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !synchronized && !differential_pulse_output_oe)
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// file: test/stc_sync_core_tb.sv
// self-checking bench for the sync core with a pulse reference model
// assumes short second, miss and tolerance counts set below
`timescale 1ns/10ps
`default_nettype none
module stc_sync_core_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, timestamp_sec;
  logic [29:0] timestamp_ns;
  logic differential_pulse_input_p, differential_pulse_input_n;
  logic differential_pulse_output_p, differential_pulse_output_n;
  logic differential_pulse_output_oe, synchronized, irq;
  logic src_en = 1'b0;
  logic [31:0] rdv;
  logic [1:0] rsp;
  int bad_count = 0;
  int n_tests = 0;
  stc_sync_core #(.CYC_PER_SEC(1000), .MISS_CYC(1500), .TOL_CYC(20)) stc_sync_core_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .differential_pulse_input_p, .differential_pulse_input_n,
    .differential_pulse_output_p, .differential_pulse_output_n, .differential_pulse_output_oe,
    .synchronized, .timestamp_sec, .timestamp_ns, .irq);
  stc_pps_src #(.PERIOD(1000), .WIDTH(50)) stc_pps_src_i (
    .aclk(aclk), .en(src_en), .p(differential_pulse_input_p), .n(differential_pulse_input_n));
  initial begin
    forever #4 aclk = ~aclk;
  end
  task automatic summarize;
    $display("mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic timeout;
    bad_count++;
    $display("BAD t=%0t wait bound used up", $time);
    summarize;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int k;
    logic aw, w, b;
    k = 0;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      k++;
      if (k > 50) timeout;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    logic ar, v;
    k = 0;
    v = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!v) begin
      @(negedge aclk);
      ar = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
      k++;
      if (k > 50) timeout;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, e);
  endtask
  task automatic sc_defaults;
    rdc(stc_pkg::A_CTRL, 32'h0000_0001);
    rdc(stc_pkg::A_THRESH, stc_pkg::THRESH_RST);
    check(32'(differential_pulse_output_oe), 32'h0000_0000);
    rd(8'h48, rdv, rsp);
    check(rdv, 32'h0000_0000);
    check(32'(rsp), 32'(stc_pkg::RESP_SLVERR));
    wr(8'h48, 32'hFFFF_FFFF, 4'hF, rsp);
    check(32'(rsp), 32'(stc_pkg::RESP_SLVERR));
  endtask
  task automatic sc_set;
    wr(stc_pkg::A_HOST_SEC, 32'h0000_1234, 4'hF, rsp);
    wr(stc_pkg::A_HOST_NS, 32'h0000_03E8, 4'hF, rsp);
    wr(stc_pkg::A_CTRL, 32'h0000_0100, 4'h2, rsp);
    cyc(2);
    check(timestamp_sec, 32'h0000_1234);
    check(32'(timestamp_ns > 30'h0000_03E8 && timestamp_ns < 30'h0000_1000), 32'h1);
    rdc(stc_pkg::A_CTRL, 32'h0000_0001);
  endtask
  task automatic sc_modes;
    for (int i = 0; i < 5; i++) begin
      wr(stc_pkg::A_CTRL, 32'(i), 4'h1, rsp);
      rdc(stc_pkg::A_CTRL, 32'(i));
    end
    wr(stc_pkg::A_CTRL, 32'(stc_pkg::MUXIN_NONE), 4'h1, rsp);
    cyc(3);
    rd(stc_pkg::A_STATUS, rdv, rsp);
    check(rdv & 32'h0000_000F, 32'h0000_0002);
    check(32'(synchronized), 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(stc_pkg::A_CTRL, 32'((i << 4) | 1), 4'h1, rsp);
      cyc(2);
      check(32'(differential_pulse_output_oe), 32'((i == 1) || (i == 3)));
    end
  endtask
  task automatic sc_pulses;
    int k;
    k = 0;
    wr(stc_pkg::A_CTRL, 32'h0000_0411, 4'h3, rsp);
    src_en <= 1'b1;
    while (differential_pulse_input_p !== 1'b1) begin
      @(posedge aclk);
      k++;
      if (k > 1100) timeout;
    end
    cyc(3);
    check(32'(differential_pulse_output_p), 32'h0000_0001);
    check(32'(differential_pulse_output_n), 32'h0000_0000);
    cyc(2500);
    rdc(stc_pkg::A_TOTAL, 32'h0000_0003);
    rdc(stc_pkg::A_BAD, 32'h0000_0000);
    rdc(stc_pkg::A_MISS, 32'h0000_0000);
  endtask
  task automatic sc_miss;
    wr(stc_pkg::A_IRQ_MASK, 32'h0000_0008, 4'h1, rsp);
    src_en <= 1'b0;
    cyc(1600);
    check(32'(irq), 32'h0000_0001);
    rdc(stc_pkg::A_MISS, 32'h0000_0001);
    wr(stc_pkg::A_CTRL, 32'h0000_0000, 4'h1, rsp);
    wr(stc_pkg::A_IRQ_MASK, 32'h0000_0000, 4'h1, rsp);
    cyc(2);
    check(32'(irq), 32'h0000_0000);
    wr(stc_pkg::A_IRQ_MASK, 32'h0000_0008, 4'h1, rsp);
    cyc(2);
    check(32'(irq), 32'h0000_0001);
    wr(stc_pkg::A_IRQ_ST, 32'h0000_0008, 4'h1, rsp);
    cyc(2);
    check(32'(irq), 32'h0000_0000);
    rdc(stc_pkg::A_IRQ_ST, 32'h0000_0000);
  endtask
  task automatic sc_master;
    wr(stc_pkg::A_CTRL, 32'h0000_0433, 4'h3, rsp);
    rdc(stc_pkg::A_CTRL, 32'h0000_0033);
    wr(stc_pkg::A_HOST_NS, 32'h0BEB_C200, 4'hF, rsp);
    wr(stc_pkg::A_CTRL, 32'h0000_0100, 4'h2, rsp);
    cyc(3);
    check(32'(differential_pulse_output_oe), 32'h0000_0001);
    check(32'(differential_pulse_output_p), 32'h0000_0000);
    wr(stc_pkg::A_HOST_NS, 32'h0000_0000, 4'hF, rsp);
    wr(stc_pkg::A_CTRL, 32'h0000_0100, 4'h2, rsp);
    cyc(3);
    check(32'(differential_pulse_output_p), 32'h0000_0001);
    wr(stc_pkg::A_CTRL, 32'h0000_0800, 4'h2, rsp);
    rdc(stc_pkg::A_TOTAL, 32'h0000_0001);
    check(32'(synchronized), 32'h0000_0001);
  endtask
  task automatic sc_reset;
    wr(stc_pkg::A_CTRL, 32'h0000_0200, 4'h2, rsp);
    cyc(2);
    rdc(stc_pkg::A_CTRL, 32'h0000_0001);
    check(32'(differential_pulse_output_oe), 32'h0000_0000);
    check(timestamp_sec, 32'h0000_1234);
    rdc(stc_pkg::A_TOTAL, 32'h0000_0000);
    wr(stc_pkg::A_CTRL, 32'h0000_0011, 4'h1, rsp);
    rdc(stc_pkg::A_CTRL, 32'h0000_0011);
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    sc_defaults;
    sc_set;
    sc_modes;
    sc_pulses;
    sc_miss;
    sc_master;
    sc_reset;
    summarize;
  end
endmodule
bind stc_sync_core stc_sync_asserts stc_sync_asserts_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .differential_pulse_output_p, .differential_pulse_output_n,
  .differential_pulse_output_oe, .synchronized, .timestamp_ns, .irq);
`default_nettype wire
